// [common/pdo_param_pkg.sv]
// Types shared by the process data trigger and parameter service
package pdo_param_pkg;
  typedef enum {ST_IDLE, ST_WAIT, ST_SEND} reqState_t;
endpackage

// [common/pdo_param_regs.svh]
// Register offsets, field values, reset values and timing counts
`ifndef PDO_PARAM_REGS_SVH
`define PDO_PARAM_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFS_NODE 12'h000
`define OFS_STATUS 12'h004
`define OFS_REQ_CODE 12'h010
`define OFS_REQ_ADDR 12'h014
`define OFS_REQ_DATA 12'h018
`define OFS_RSP_CODE 12'h020
`define OFS_RSP_ERR 12'h024
`define OFS_RSP_DATA 12'h028
`define OFS_CFG_MASK 12'hFC0
`define OFS_CFG_BASE 12'h040
`define SUB_TYPE 4'h0
`define SUB_INH 4'h4
`define SUB_EVT 4'h8
// ****************************************
// Reset values
// ****************************************
`define RST_NODE 7'h01
`define RST_TYPE_FIRST 8'hFF
`define RST_TYPE_OTHER 8'hFE
`define RST_EVT 16'h0000
`define RST_INH 16'h01F4
// ****************************************
// Transmission types and timing
// ****************************************
`define TYPE_SYNC_MAX 8'hF0
`define TYPE_ASYNC_CHG 8'hFE
`define TYPE_ASYNC_RX 8'hFF
`define INH_MIN_MS 16'h0032
`define MS_NS 1000000
`define CLK_PERIOD_NS 100
// ****************************************
// Frame identifiers and codes
// ****************************************
`define REQ_ID_BASE 11'h200
`define RSP_ID_BASE 11'h180
`define RPDO_STEP 11'h100
`define REQ_DLC 4'h6
`define RQ_NONE 16'h0000
`define RQ_READ 16'h0001
`define RQ_WRITE 16'h0002
`define RS_NONE 16'h0000
`define RS_OK 16'h0001
`define RS_FAIL 16'h0003
`define ERR_NONE 16'h0000
`define ERR_ILL_REQ 16'h0001
`define ERR_BAD_ADDR 16'h0002
`define ERR_ILL_VAL 16'h0003
`define ERR_OP_FAIL 16'h0004
`define ERR_PASSWORD 16'h0005
`define ERR_FRAME 16'h0006
`define ERR_READ_ONLY 16'h0007
`define ERR_RUNNING 16'h0008
`define ERR_LOCKED 16'h0009
`endif

// [src/canopen_pdo_trigger.sv]
// Transmit trigger scheduler and parameter request service
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "pdo_param_regs.svh"
module canopen_pdo_trigger #(
  parameter int NUM_PDO = 4,
  parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received frames from the CAN controller
  input wire logic rxValid,
  input wire logic [10:0] rxId,
  input wire logic [3:0] rxDlc,
  input wire logic [63:0] rxData,
  // Bus events and mapped data changes
  input wire logic syncPulse,
  input wire logic [NUM_PDO-1:0] dataChanged,
  // Transmit requests and the parameter response frame
  output logic [NUM_PDO-1:0] txReq,
  output logic [10:0] respId,
  output logic [63:0] respData,
  output logic emcyReq,
  // Parameter store
  output logic paramReq,
  output logic paramWrite,
  output logic [15:0] paramAddr,
  output logic [15:0] paramWdata,
  input wire logic paramAck,
  input wire logic [15:0] paramRdata,
  input wire logic paramFail,
  input wire logic [15:0] paramErrCode
);
  // ****************************************
  // Declarations
  // ****************************************
  localparam int MSW = $clog2(MS_CYCLES + 1);
  logic [MSW-1:0] msCnt_r;
  logic msTick_r;
  logic [6:0] node_r;
  logic [7:0] txType_r [NUM_PDO];
  logic [15:0] inhibit_r [NUM_PDO];
  logic [15:0] evtTimer_r [NUM_PDO];
  logic [NUM_PDO-1:0] trig;
  logic [NUM_PDO-1:0] txReq_r;
  pdo_param_pkg::reqState_t state_r;
  logic [15:0] reqCode_r, reqAddr_r, reqData_r;
  logic [15:0] rspCode_r, rspErr_r, rspData_r;
  logic rspDone_r;
  logic emcy_r;
  logic paramReq_r, paramWrite_r;
  logic [10:0] respId_r;
  logic [63:0] respData_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic apbWr, apbRd, reqHit;
  logic [31:0] rdVal;
  logic rdOk;
  logic cfgSel;
  logic [1:0] cfgIdx;
  // ****************************************
  // Millisecond time base
  // ****************************************
  // Millisecond tick
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      msCnt_r <= '0;
      msTick_r <= 1'b0;
    end else if (msCnt_r == MSW'(MS_CYCLES - 1)) begin
      msCnt_r <= '0;
      msTick_r <= 1'b1;
    end else begin
      msCnt_r <= msCnt_r + 1'b1;
      msTick_r <= 1'b0;
    end
  end
  // ****************************************
  // APB slave
  // ****************************************
  // Write lands at the edge where pready is seen high
  assign apbWr = psel && penable && pwrite && pready_r;
  assign apbRd = psel && penable && !pready_r;
  assign cfgSel = (paddr & `OFS_CFG_MASK) == `OFS_CFG_BASE;
  assign cfgIdx = paddr[5:4];
  // Read decode, unmapped gives error
  always_comb begin
    rdVal = 32'h0000_0000;
    rdOk = 1'b1;
    if (cfgSel && paddr[3:0] == `SUB_TYPE) begin
      rdVal = {24'h00_0000, txType_r[cfgIdx]};
    end else if (cfgSel && paddr[3:0] == `SUB_INH) begin
      rdVal = {16'h0000, inhibit_r[cfgIdx]};
    end else if (cfgSel && paddr[3:0] == `SUB_EVT) begin
      rdVal = {16'h0000, evtTimer_r[cfgIdx]};
    end else begin
      case (paddr)
        `OFS_NODE: rdVal = {25'h000_0000, node_r};
        `OFS_STATUS: rdVal = {30'h0000_0000, paramReq_r,
                              state_r != pdo_param_pkg::ST_IDLE};
        `OFS_REQ_CODE: rdVal = {16'h0000, reqCode_r};
        `OFS_REQ_ADDR: rdVal = {16'h0000, reqAddr_r};
        `OFS_REQ_DATA: rdVal = {16'h0000, reqData_r};
        `OFS_RSP_CODE: rdVal = {16'h0000, rspCode_r};
        `OFS_RSP_ERR: rdVal = {16'h0000, rspErr_r};
        `OFS_RSP_DATA: rdVal = {16'h0000, rspData_r};
        default: rdOk = 1'b0;
      endcase
    end
  end
  // One wait state, then answer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= apbRd;
      pslverr_r <= apbRd && !rdOk;
      prdata_r <= (apbRd && !pwrite) ? rdVal : 32'h0000_0000;
    end
  end
  // Node number
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      node_r <= `RST_NODE;
    end else if (apbWr && paddr == `OFS_NODE) begin
      node_r <= pwdata[6:0];
    end
  end
  // ****************************************
  // Parameter request service
  // ****************************************
  // Request identifier match
  assign reqHit = rxValid && rxId == `REQ_ID_BASE + {4'h0, node_r};
  // Request, store access and response build
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= pdo_param_pkg::ST_IDLE;
      reqCode_r <= `RQ_NONE;
      reqAddr_r <= 16'h0000;
      reqData_r <= 16'h0000;
      rspCode_r <= `RS_NONE;
      rspErr_r <= `ERR_NONE;
      rspData_r <= 16'h0000;
      rspDone_r <= 1'b0;
      emcy_r <= 1'b0;
      paramReq_r <= 1'b0;
      paramWrite_r <= 1'b0;
    end else begin
      rspDone_r <= 1'b0;
      emcy_r <= 1'b0;
      case (state_r)
        pdo_param_pkg::ST_IDLE: begin
          if (reqHit && rxDlc != `REQ_DLC) begin
            emcy_r <= 1'b1;
          end else if (reqHit) begin
            reqCode_r <= rxData[15:0];
            reqAddr_r <= rxData[31:16];
            reqData_r <= rxData[47:32];
            state_r <= pdo_param_pkg::ST_SEND;
            case (rxData[15:0])
              `RQ_READ, `RQ_WRITE: begin
                paramReq_r <= 1'b1;
                paramWrite_r <= rxData[15:0] == `RQ_WRITE;
                state_r <= pdo_param_pkg::ST_WAIT;
              end
              `RQ_NONE: begin
                rspCode_r <= `RS_NONE;
                rspErr_r <= `ERR_NONE;
                rspData_r <= 16'h0000;
              end
              default: begin
                rspCode_r <= `RS_FAIL;
                rspErr_r <= `ERR_ILL_REQ;
                rspData_r <= 16'h0000;
              end
            endcase
          end
        end
        pdo_param_pkg::ST_WAIT: begin
          if (paramAck) begin
            paramReq_r <= 1'b0;
            state_r <= pdo_param_pkg::ST_SEND;
            rspCode_r <= paramFail ? `RS_FAIL : `RS_OK;
            rspErr_r <= paramFail ? paramErrCode : `ERR_NONE;
            rspData_r <= paramWrite_r ? reqData_r : paramRdata;
          end
        end
        pdo_param_pkg::ST_SEND: begin
          rspDone_r <= 1'b1;
          state_r <= pdo_param_pkg::ST_IDLE;
        end
        default: state_r <= pdo_param_pkg::ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      respId_r <= `RSP_ID_BASE;
      respData_r <= 64'h0000_0000_0000_0000;
    end else if (state_r == pdo_param_pkg::ST_SEND) begin
      respId_r <= `RSP_ID_BASE + {4'h0, node_r};
      respData_r <= {16'h0000, rspData_r, rspErr_r, rspCode_r};
    end
  end
  // ****************************************
  // Per-object configuration and scheduler
  // ****************************************
  // One slice per transmit object
  genvar k;
  generate
    for (k = 0; k < NUM_PDO; k++) begin : g_pdo
      logic [7:0] syncCnt_r;
      logic [15:0] inhCnt_r, evtCnt_r;
      logic pending_r;
      logic [15:0] effInh;
      logic isSync, evtOn, fire;
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          txType_r[k] <= (k == 0) ? `RST_TYPE_FIRST : `RST_TYPE_OTHER;
          inhibit_r[k] <= `RST_INH;
          evtTimer_r[k] <= `RST_EVT;
        end else if (apbWr && cfgSel && cfgIdx == 2'(k)) begin
          if (paddr[3:0] == `SUB_TYPE) begin
            txType_r[k] <= pwdata[7:0];
          end
          if (paddr[3:0] == `SUB_INH) begin
            inhibit_r[k] <= pwdata[15:0];
          end
          if (paddr[3:0] == `SUB_EVT) begin
            evtTimer_r[k] <= pwdata[15:0];
          end
        end
      end
      // Receive trigger, first object answers the request
      if (k == 0) begin : g_rsp
        assign trig[k] = rspDone_r;
      end else begin : g_rx
        assign trig[k] = rxValid && rxId == 11'(`REQ_ID_BASE
                         + k * `RPDO_STEP) + {4'h0, node_r};
      end
      assign effInh = (inhibit_r[k] < `INH_MIN_MS) ? `INH_MIN_MS
                      : inhibit_r[k];
      assign isSync = txType_r[k] != 8'h00 &&
                      txType_r[k] <= `TYPE_SYNC_MAX;
      assign evtOn = evtTimer_r[k] != 16'h0000;
      // Send decision per mode
      always_comb begin
        fire = 1'b0;
        if (isSync) begin
          fire = syncPulse && (syncCnt_r + 8'h01 >= txType_r[k]);
        end else if ((txType_r[k] == `TYPE_ASYNC_CHG ||
                      txType_r[k] == `TYPE_ASYNC_RX) && evtOn) begin
          fire = msTick_r && (evtCnt_r + 16'h0001 >= evtTimer_r[k]);
        // Change of data, one per inhibit window
        end else if (txType_r[k] == `TYPE_ASYNC_CHG) begin
          fire = (pending_r || dataChanged[k]) && inhCnt_r >= effInh;
        end else if (txType_r[k] == `TYPE_ASYNC_RX) begin
          fire = trig[k];
        end
      end
      // SYNC counter
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          syncCnt_r <= 8'h00;
        end else if (!isSync || fire) begin
          syncCnt_r <= 8'h00;
        end else if (syncPulse) begin
          syncCnt_r <= syncCnt_r + 8'h01;
        end
      end
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          inhCnt_r <= 16'h0000;
          evtCnt_r <= 16'h0000;
        end else if (fire) begin
          inhCnt_r <= 16'h0000;
          evtCnt_r <= 16'h0000;
        end else if (msTick_r) begin
          if (inhCnt_r != 16'hFFFF) begin
            inhCnt_r <= inhCnt_r + 16'h0001;
          end
          if (evtOn && evtCnt_r != 16'hFFFF) begin
            evtCnt_r <= evtCnt_r + 16'h0001;
          end
        end
      end
      // Held change until the window opens
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          pending_r <= 1'b0;
        end else if (txType_r[k] != `TYPE_ASYNC_CHG || evtOn || fire) begin
          pending_r <= 1'b0;
        end else if (dataChanged[k]) begin
          pending_r <= 1'b1;
        end
      end
      // Transmit request pulse
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          txReq_r[k] <= 1'b0;
        end else begin
          txReq_r[k] <= fire;
        end
      end
    end
  endgenerate
  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign txReq = txReq_r;
  assign respId = respId_r;
  assign respData = respData_r;
  assign emcyReq = emcy_r;
  assign paramReq = paramReq_r;
  assign paramWrite = paramWrite_r;
  // Request data only used by writes
  assign paramAddr = reqAddr_r;
  assign paramWdata = reqData_r;
endmodule

// [tb/canopen_pdo_trigger_asserts.sv]
// Port checker for the trigger and parameter service
`timescale 1ns/100ps
module canopen_pdo_trigger_asserts #(
  parameter int NUM_PDO = 4,
  parameter int MS_CYCLES = 10000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Frames
  input wire logic rxValid,
  input wire logic [10:0] rxId,
  input wire logic [3:0] rxDlc,
  input wire logic [63:0] rxData,
  input wire logic [NUM_PDO-1:0] txReq,
  input wire logic [10:0] respId,
  input wire logic [63:0] respData,
  input wire logic emcyReq,
  // Parameter store
  input wire logic paramReq,
  input wire logic paramWrite,
  input wire logic [15:0] paramAddr,
  input wire logic [15:0] paramWdata,
  input wire logic paramAck,
  input wire logic [15:0] paramRdata,
  input wire logic paramFail,
  input wire logic [15:0] paramErrCode
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence sAck;
    paramReq && paramAck;
  endsequence
  sequence sOk;
    sAck ##0 !paramFail;
  endsequence
  sequence sNak;
    sAck ##0 paramFail;
  endsequence
  // One wait state
  AST_APB_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_RD_IDLE: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside answer");
  AST_EMCY_LEN: assert property (
    emcyReq |-> $past(rxValid) && $past(rxDlc) != 4'h6)
    else $error("emergency without bad length");
  AST_REQ_START: assert property (
    $rose(paramReq) |-> $past(rxValid) && $past(rxDlc) == 4'h6
    && $past(rxId) == 11'h201 && paramAddr == $past(rxData[31:16])
    && paramWrite == ($past(rxData[15:0]) == 16'h0002))
    else $error("store request without valid frame");
  AST_REQ_HOLD: assert property (
    paramReq && !paramAck |=> paramReq && $stable(paramAddr))
    else $error("store request dropped");
  AST_RSP_OK: assert property (
    sOk |-> ##3 txReq[0] && respData[15:0] == 16'h0001
    && respData[47:32] == ($past(paramWrite, 3) ?
    $past(paramWdata, 3) : $past(paramRdata, 3)))
    else $error("success response wrong");
  AST_RSP_FAIL: assert property (
    sNak |-> ##3 txReq[0] && respData[15:0] == 16'h0003
    && respData[31:16] == $past(paramErrCode, 3))
    else $error("failure response wrong");
  AST_RSP_FRAME: assert property (
    txReq[0] |-> respId == 11'h181 && respData[63:48] == 16'h0000)
    else $error("response frame id or tail wrong");
  AST_TX0_CAUSE: assert property (
    txReq[0] |-> $past(paramAck, 3) || $past(rxValid, 3))
    else $error("response without cause");
endmodule
bind canopen_pdo_trigger canopen_pdo_trigger_asserts #(
  .NUM_PDO(NUM_PDO), .MS_CYCLES(MS_CYCLES)) chk (.ref_clk(ref_clk),
  .arst_n(arst_n), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxValid(rxValid), .rxId(rxId),
  .rxDlc(rxDlc), .rxData(rxData), .txReq(txReq), .respId(respId),
  .respData(respData), .emcyReq(emcyReq), .paramReq(paramReq),
  .paramWrite(paramWrite), .paramAddr(paramAddr),
  .paramWdata(paramWdata), .paramAck(paramAck), .paramRdata(paramRdata),
  .paramFail(paramFail), .paramErrCode(paramErrCode));

// [tb/param_store_model.sv]
// Parameter store model answering the service
`timescale 1ns/100ps
module param_store_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Request side
  input wire logic paramReq,
  input wire logic [15:0] paramAddr,
  // Answer side
  output logic paramAck,
  output logic [15:0] paramRdata,
  output logic paramFail,
  output logic [15:0] paramErrCode
);
  int cnt;
  // ****************************************
  // Answer, prompt on even, slow on odd address
  // ****************************************
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      paramAck <= 1'b0;
      paramFail <= 1'b0;
      paramRdata <= 16'hA5A5;
      paramErrCode <= 16'h0000;
    end else begin
      paramAck <= 1'b0;
      paramFail <= 1'b0;
      paramRdata <= ~paramRdata;
      paramErrCode <= ~paramErrCode;
      if (paramAck) begin
        cnt <= 0;
      end else if (paramReq) begin
        cnt <= cnt + 1;
        if (cnt == (paramAddr[0] ? 4 : 0)) begin
          paramAck <= 1'b1;
          paramFail <= (paramAddr[15:8] == 8'hEE);
          paramErrCode <= 16'h0002;
          paramRdata <= ~paramAddr;
        end
      end
    end
  end
endmodule

// [tb/testbench.sv]
// Self-checking bench of the trigger and parameter service
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic ref_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic rxValid, syncPulse, emcyReq, paramReq, paramWrite, paramAck;
  logic paramFail;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [10:0] rxId, respId;
  logic [3:0] rxDlc, dataChanged, txReq;
  logic [63:0] rxData, respData;
  logic [15:0] paramAddr, paramWdata, paramRdata, paramErrCode, lfsr;
  logic e;
  int n_errors, n_compared, t, h;
  // ****************************************
  // Instances, clock, tasks
  // ****************************************
  canopen_pdo_trigger #(.MS_CYCLES(10)) dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxValid(rxValid), .rxId(rxId), .rxDlc(rxDlc),
    .rxData(rxData), .syncPulse(syncPulse), .dataChanged(dataChanged),
    .txReq(txReq), .respId(respId), .respData(respData),
    .emcyReq(emcyReq), .paramReq(paramReq), .paramWrite(paramWrite),
    .paramAddr(paramAddr), .paramWdata(paramWdata), .paramAck(paramAck),
    .paramRdata(paramRdata), .paramFail(paramFail),
    .paramErrCode(paramErrCode));
  param_store_model store (.ref_clk(ref_clk), .arst_n(arst_n),
    .paramReq(paramReq), .paramAddr(paramAddr), .paramAck(paramAck),
    .paramRdata(paramRdata), .paramFail(paramFail),
    .paramErrCode(paramErrCode));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic apb(input bit w, input logic [11:0] a, input int d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rx(input logic [10:0] id, input logic [3:0] n,
      input logic [63:0] d);
    @(posedge ref_clk);
    rxValid <= 1'b1;
    rxId <= id;
    rxDlc <= n;
    rxData <= d;
    @(posedge ref_clk);
    rxValid <= 1'b0;
    rxData <= ~d;
  endtask
  task automatic waitTx(input int i, output int k);
    k = 0;
    // A pulse launched at the caller's edge is seen too
    #1;
    while (!(i < 4 ? txReq[i] === 1'b1 : emcyReq === 1'b1)
        && k < 2000) begin
      @(posedge ref_clk);
      #1 k++;
    end
    `CHK(k < 2000, 1'b1)
    // Let the found pulse end before the next wait
    @(posedge ref_clk);
  endtask
  task automatic doReq(input logic [15:0] c, a, d, input logic [3:0] n);
    logic [15:0] ec, ee, ed;
    ee = 16'h0000;
    ed = (c == 16'h0001) ? ~a : d;
    ec = (c > 16'h0002) ? 16'h0003 : (c == 16'h0000) ? 16'h0000 :
      (a[15:8] == 8'hEE) ? 16'h0003 : 16'h0001;
    if (ec == 16'h0003) ee = (c > 16'h0002) ? 16'h0001 : 16'h0002;
    rx(11'h201, n, {16'h0000, d, a, c});
    if (n != 4'h6) begin
      waitTx(4, t);
    end else begin
      waitTx(0, t);
      `CHK(respId, 11'h181)
      `CHK(respData[15:0], ec)
      `CHK(respData[63:48], 16'h0000)
      if (ec == 16'h0003) `CHK(respData[31:16], ee)
      if (ec == 16'h0001) `CHK(respData[47:32], ed)
      apb(0, 12'h010, 0);
      `CHK(r[15:0], c)
      apb(0, 12'h020, 0);
      `CHK(r[15:0], ec)
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    n_errors++;
    give_verdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, rxValid, syncPulse} = 5'h00;
    {paddr, pwdata, rxId, rxDlc, rxData, dataChanged} = '0;
    lfsr = 16'h0014;
    arst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    apb(0, 12'h000, 0);
    `CHK(r[6:0], 7'h01)
    for (int k = 0; k < 4; k++) begin
      apb(0, 12'h040 + 12'(16 * k), 0);
      `CHK(r[7:0], (k == 0) ? 8'hFF : 8'hFE)
      apb(0, 12'h044 + 12'(16 * k), 0);
      `CHK(r[15:0], 16'h01F4)
      apb(0, 12'h048 + 12'(16 * k), 0);
      `CHK(r[15:0], 16'h0000)
    end
    apb(0, 12'hFFC, 0);
    `CHK(e, 1'b1)
    // first object left at 255 without timer throughout
    // group in high byte, number in low byte
    for (int i = 0; i < 7; i++) begin
      lfsr = nxt(lfsr);
      doReq((i > 3) ? 16'(i - 3) : 16'(i * i % 5 + i), (i > 3) ?
        {8'hEE, lfsr[7:0]} : {1'b0, lfsr[14:0]}, ~lfsr, (i == 6) ?
        4'h5 : 4'h6);
    end
    apb(1, 12'h050, 3);
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk) syncPulse <= 1'b1;
      @(posedge ref_clk) syncPulse <= 1'b0;
      #1 h = int'(txReq[1] === 1'b1);
      repeat (6) @(posedge ref_clk) #1 h += int'(txReq[1] === 1'b1);
      `CHK(h, int'(i % 3 == 2))
    end
    apb(1, 12'h050, 8'hFF);
    rx(11'h301, 4'h8, {lfsr, lfsr, lfsr, lfsr});
    waitTx(1, t);
    `CHK(t <= 4, 1'b1)
    for (int ty = 254; ty < 256; ty++) begin
      apb(1, 12'h060, ty);
      apb(1, 12'h068, 3);
      waitTx(2, t);
      waitTx(2, t);
      // Three ms of ten cycles, less the edge that closes a wait
      `CHK(t, 3 * 10 - 1)
      waitTx(2, t);
      `CHK(t, 3 * 10 - 1)
    end
    apb(1, 12'h068, 0);
    apb(1, 12'h074, 10);
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk) dataChanged <= 4'h8;
      @(posedge ref_clk) dataChanged <= 4'h0;
      waitTx(3, t);
    end
    `CHK(t >= 480 && t <= 505, 1'b1)
    give_verdict();
  end
endmodule
